/* bus_node_cfg.svh */
`ifndef BUS_NODE_CFG_SVH
`define BUS_NODE_CFG_SVH

// Clock and time-state timing
`define CLK_MHZ 250
`define TS_NS 50
`define TS_CYCLES ((`TS_NS * `CLK_MHZ) / 1000)

// Format tags
`define TAG_RDATA 3'h0
`define TAG_CMD 3'h3
`define TAG_WDATA 3'h5

// Function codes of a command/address word
`define FN_READ 4'h1
`define FN_WRITE 4'h2
`define FN_ILK_READ 4'h5
`define FN_ILK_WRITE 4'h6
`define FN_EXT_READ 4'h9
`define FN_EXT_WRITE 4'hA

// Information field layout
`define FN_MSB 31
`define FN_LSB 28
`define IO_SPACE_BIT 27

// Read data integrity codes
`define INTEG_OK 4'h0
`define INTEG_CORRECTED 4'h1
`define INTEG_UNCORRECTABLE 4'h2

// Confirmation codes
`define CNF_NONE 2'h0
`define CNF_ACK 2'h1
`define CNF_BUSY 2'h2
`define CNF_ERR 2'h3

// Hold line and storage
`define HOLD_LINE 0
`define MEM_WORDS 16
`define MEM_IDX_W 4

`endif

/* bus_types_pkg.sv */
`include "bus_node_cfg.svh"

package bus_types_pkg;

	typedef struct packed {
		logic [1:0] par;
		logic [2:0] tag;
		logic [4:0] id;
		logic [3:0] mask;
		logic [31:0] data;
	} info_t;

	typedef enum logic [3:0] {
		M_IDLE = 4'b0001,
		M_WDATA = 4'b0010,
		M_ARB = 4'b0100,
		M_SEND = 4'b1000
	} mem_state_t;

	typedef enum logic [4:0] {
		N_IDLE = 5'b00001,
		N_ARB = 5'b00010,
		N_CMD = 5'b00100,
		N_WDATA = 5'b01000,
		N_WAIT = 5'b10000
	} node_state_t;

	// Builds a transfer with both even parity bits filled in
	function automatic info_t make_info(logic [2:0] tag, logic [4:0] id, logic [3:0] mask,
		logic [31:0] data);
		info_t v;
		v.tag = tag;
		v.id = id;
		v.mask = mask;
		v.data = data;
		v.par = {^data, ^{tag, id, mask}};
		return v;
	endfunction

	function automatic logic parity_ok(info_t v);
		return (^{v.tag, v.id, v.mask, v.par[0]} == 1'b0) && (^{v.data, v.par[1]} == 1'b0);
	endfunction

	function automatic logic is_read(logic [3:0] fn);
		return fn == `FN_READ || fn == `FN_ILK_READ || fn == `FN_EXT_READ;
	endfunction

	function automatic logic is_write(logic [3:0] fn);
		return fn == `FN_WRITE || fn == `FN_ILK_WRITE || fn == `FN_EXT_WRITE;
	endfunction

	function automatic logic is_ext(logic [3:0] fn);
		return fn == `FN_EXT_READ || fn == `FN_EXT_WRITE;
	endfunction

	// Request lines that outrank the given line, hold line included
	function automatic logic [15:0] higher_lines(int line);
		return 16'((32'h1 << line) - 32'h1);
	endfunction

	// Replaces only the byte lanes selected by the mask
	function automatic logic [31:0] merge_bytes(logic [31:0] old, logic [31:0] nw,
		logic [3:0] mask);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (mask[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

endpackage

/* node_bus_if.sv */
`timescale 1ns/100ps

interface node_bus_if;
	import bus_types_pkg::*;

	logic [15:0] mem_req_lines;
	logic [15:0] node_req_lines;
	logic [15:0] req_lines;
	info_t mem_info;
	logic mem_info_oe;
	info_t node_info;
	logic node_info_oe;
	info_t info;
	logic [1:0] mem_cnf;
	logic [1:0] node_cnf;
	logic [1:0] cnf;

	// Wired-OR lines; an undriven information path rests at all zeros
	assign req_lines = mem_req_lines | node_req_lines;
	assign info = (mem_info_oe ? mem_info : '0) | (node_info_oe ? node_info : '0);
	assign cnf = mem_cnf | node_cnf;

	modport mem_end(output mem_req_lines, output mem_info, output mem_info_oe,
		output mem_cnf, input req_lines, input info, input cnf);
	modport node_end(output node_req_lines, output node_info, output node_info_oe,
		output node_cnf, input req_lines, input info, input cnf);
endinterface

/* cmd_node_end.sv */
`timescale 1ns/100ps
`include "bus_node_cfg.svh"

module cmd_node_end import bus_types_pkg::*; #(
	parameter int NODE_LINE = 5
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	node_bus_if.node_end bus,
	input wire logic req_valid_i,
	input wire logic [3:0] req_func_i,
	input wire logic [27:0] req_addr_i,
	input wire logic [7:0] req_mask_i,
	input wire logic [63:0] req_wdata_i,
	output logic req_ready_o,
	output logic rsp_valid_o,
	output logic [31:0] rsp_data_o,
	output logic [3:0] rsp_integrity_o,
	output logic rsp_err_o
);

	localparam logic [4:0] NODE_ID = 5'(NODE_LINE);

	node_state_t state_reg, state_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [1:0] ts_reg, ts_next;
	info_t lat_reg, lat_next;
	logic [15:0] ltr_reg, ltr_next;
	logic [1:0] lcnf_reg, lcnf_next;
	logic [15:0] trv_reg, trv_next;
	info_t out_reg, out_next;
	logic oe_reg, oe_next;
	logic [1:0] cnf_pend_reg, cnf_pend_next;
	logic [1:0] cnf_out_reg, cnf_out_next;
	logic [3:0] fn_reg, fn_next;
	logic [27:0] addr_reg, addr_next;
	logic [7:0] mask_reg, mask_next;
	logic [63:0] wdata_reg, wdata_next;
	logic first_reg, first_next;
	logic [2:0] bc_reg, bc_next;
	logic ready_reg, ready_next;
	logic rv_reg, rv_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [3:0] rint_reg, rint_next;
	logic rerr_reg, rerr_next;
	logic tick;
	logic [2:0] last_cnf;

	assign tick = cnt_reg == 4'(`TS_CYCLES - 1);
	// Bus cycle whose confirmation ends a write: after the last data word
	assign last_cnf = is_ext(fn_reg) ? 3'h4 : 3'h3;

	////////////////////////////////////////////////////////////////////////////////////////
	// Next-state logic of the whole node
	always_comb begin
		cnt_next = tick ? 4'h0 : cnt_reg + 4'h1;
		ts_next = tick ? ts_reg + 2'h1 : ts_reg; // RULE_24
		state_next = state_reg;
		lat_next = lat_reg;
		ltr_next = ltr_reg;
		lcnf_next = lcnf_reg;
		trv_next = trv_reg;
		out_next = out_reg;
		oe_next = oe_reg;
		cnf_pend_next = cnf_pend_reg;
		cnf_out_next = cnf_out_reg;
		fn_next = fn_reg;
		addr_next = addr_reg;
		mask_next = mask_reg;
		wdata_next = wdata_reg;
		first_next = first_reg;
		bc_next = bc_reg;
		ready_next = ready_reg;
		rv_next = 1'b0;
		rdata_next = rdata_reg;
		rint_next = rint_reg;
		rerr_next = rerr_reg;
		if (state_reg == N_IDLE && ready_reg && req_valid_i) begin
			fn_next = req_func_i;
			addr_next = req_addr_i;
			mask_next = req_mask_i;
			wdata_next = req_wdata_i;
			ready_next = 1'b0;
			state_next = N_ARB;
		end
		if (tick && ts_reg == 2'h2) begin
			lat_next = bus.info; // RULE_21
			ltr_next = bus.req_lines;
			lcnf_next = bus.cnf;
		end
		if (tick && ts_reg == 2'h3) begin
			cnf_out_next = cnf_pend_reg; // RULE_22
			cnf_pend_next = `CNF_NONE;
			if (state_reg == N_CMD || state_reg == N_WDATA || state_reg == N_WAIT) begin
				bc_next = bc_reg + 3'h1;
			end
			case (state_reg)
				N_ARB: begin
					if (!trv_reg[NODE_LINE]) begin
						trv_next[NODE_LINE] = 1'b1; // RULE_03
					end else if ((ltr_reg & higher_lines(NODE_LINE)) == 16'h0) begin // RULE_04
						trv_next[NODE_LINE] = 1'b0;
						trv_next[`HOLD_LINE] = is_write(fn_reg); // RULE_05
						oe_next = 1'b1;
						// RULE_09 RULE_16 RULE_18
						out_next = make_info(`TAG_CMD, NODE_ID, mask_reg[3:0], {fn_reg, addr_reg});
						bc_next = 3'h0;
						first_next = 1'b1;
						state_next = N_CMD;
					end
				end
				N_CMD: begin
					if (is_write(fn_reg)) begin
						// RULE_14 RULE_15 RULE_17
						out_next = make_info(`TAG_WDATA, NODE_ID, mask_reg[3:0], wdata_reg[31:0]);
						trv_next[`HOLD_LINE] = is_ext(fn_reg);
						state_next = N_WDATA;
					end else begin
						oe_next = 1'b0;
						trv_next[`HOLD_LINE] = 1'b0;
						state_next = N_WAIT;
					end
				end
				N_WDATA: begin
					if (is_ext(fn_reg) && first_reg) begin
						out_next = make_info(`TAG_WDATA, NODE_ID, mask_reg[7:4], wdata_reg[63:32]);
						first_next = 1'b0;
						trv_next[`HOLD_LINE] = 1'b0;
					end else begin
						oe_next = 1'b0;
						state_next = N_WAIT;
					end
				end
				N_WAIT: begin
					if (bc_reg == 3'h2 && lcnf_reg != `CNF_ACK) begin
						rv_next = 1'b1;
						rerr_next = 1'b1;
						state_next = N_IDLE;
						ready_next = 1'b1;
					end else if (is_write(fn_reg) && bc_reg == last_cnf) begin
						rv_next = 1'b1;
						rerr_next = lcnf_reg != `CNF_ACK;
						state_next = N_IDLE;
						ready_next = 1'b1;
					end else if (is_read(fn_reg) && parity_ok(lat_reg)
						&& lat_reg.tag == `TAG_RDATA && lat_reg.id == NODE_ID) begin // RULE_12
						cnf_pend_next = `CNF_ACK;
						rv_next = 1'b1;
						rerr_next = 1'b0;
						rdata_next = lat_reg.data; // RULE_19
						rint_next = lat_reg.mask;
						first_next = 1'b0;
						if (!(is_ext(fn_reg) && first_reg)) begin
							state_next = N_IDLE;
							ready_next = 1'b1;
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Registers; oe_reg gates the information outputs, which keeps the lines at zero when idle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= N_IDLE;
			cnt_reg <= 4'h0;
			ts_reg <= 2'h0;
			lat_reg <= '0;
			ltr_reg <= 16'h0;
			lcnf_reg <= `CNF_NONE;
			trv_reg <= 16'h0;
			out_reg <= '0;
			oe_reg <= 1'b0;
			cnf_pend_reg <= `CNF_NONE;
			cnf_out_reg <= `CNF_NONE;
			fn_reg <= 4'h0;
			addr_reg <= 28'h0;
			mask_reg <= 8'h0;
			wdata_reg <= 64'h0;
			first_reg <= 1'b0;
			bc_reg <= 3'h0;
			ready_reg <= 1'b1;
			rv_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rint_reg <= 4'h0;
			rerr_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			ts_reg <= ts_next;
			lat_reg <= lat_next;
			ltr_reg <= ltr_next;
			lcnf_reg <= lcnf_next;
			trv_reg <= trv_next;
			out_reg <= out_next;
			oe_reg <= oe_next;
			cnf_pend_reg <= cnf_pend_next;
			cnf_out_reg <= cnf_out_next;
			fn_reg <= fn_next;
			addr_reg <= addr_next;
			mask_reg <= mask_next;
			wdata_reg <= wdata_next;
			first_reg <= first_next;
			bc_reg <= bc_next;
			ready_reg <= ready_next;
			rv_reg <= rv_next;
			rdata_reg <= rdata_next;
			rint_reg <= rint_next;
			rerr_reg <= rerr_next;
		end
	end

	assign bus.node_req_lines = trv_reg; // RULE_01
	assign bus.node_info = out_reg; // RULE_07
	assign bus.node_info_oe = oe_reg;
	assign bus.node_cnf = cnf_out_reg;
	assign req_ready_o = ready_reg;
	assign rsp_valid_o = rv_reg;
	assign rsp_data_o = rdata_reg;
	assign rsp_integrity_o = rint_reg;
	assign rsp_err_o = rerr_reg;

endmodule

/* mem_node_end.sv */
// Function
// (RULE_01) One request line per node, 00 highest
// (RULE_02) Line 00 is only the hold signal
// (RULE_03) Request at state 0, sample at 3
// (RULE_04) No higher request: drive at next 0
// (RULE_05) Write-type winner also asserts the hold
// (RULE_06) Loser keeps requesting and rechecks each cycle
// (RULE_07) Even parity over control and information fields
// (RULE_08) Odd parity flagged; idle zeros are valid
// (RULE_09) Tag 011 is command, ID is commander
// (RULE_10) Read answer carries the received identifier
// (RULE_11) 28-bit address; bit 27 selects I/O
// (RULE_12) Tag 000 is read data to requester
// (RULE_13) Read mask encodes data integrity
// (RULE_14) Tag 101 is write data for command
// (RULE_15) Write data follows command cycle directly
// (RULE_16) Identifier equals request line; memory none
// (RULE_17) Mask bits select byte lanes
// (RULE_18) Four-bit function plus 28-bit address
// (RULE_19) Read data always a full longword
// (RULE_20) Memory writes only masked byte lanes
// (RULE_21) Latch at state 2, use at 3
// (RULE_22) Confirmation two bus cycles after transfer
// (RULE_23) Decode the six memory function codes
// (RULE_24) Four time states per bus cycle
`timescale 1ns/100ps
`include "bus_node_cfg.svh"

module mem_node_end import bus_types_pkg::*; #(
	parameter int MEM_LINE = 2
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	node_bus_if.mem_end bus,
	output logic busy_o,
	output logic parity_err_o
);

	mem_state_t state_reg, state_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [1:0] ts_reg, ts_next;
	info_t lat_reg, lat_next;
	logic [15:0] ltr_reg, ltr_next;
	logic [15:0] trv_reg, trv_next;
	info_t out_reg, out_next;
	logic oe_reg, oe_next;
	logic [1:0] cnf_pend_reg, cnf_pend_next;
	logic [1:0] cnf_out_reg, cnf_out_next;
	logic [4:0] id_reg, id_next;
	logic [`MEM_IDX_W-1:0] idx_reg, idx_next;
	logic ext_reg, ext_next;
	logic busy_reg, busy_next;
	logic perr_reg, perr_next;
	logic mem_we;
	logic [`MEM_IDX_W-1:0] mem_widx;
	logic [31:0] mem_wword;
	logic [31:0] mem_reg [`MEM_WORDS];
	logic mem_par_reg [`MEM_WORDS];
	logic tick;
	logic act;
	logic xfer_ok;
	logic mem_cmd;
	logic [3:0] fn;
	logic [`MEM_IDX_W-1:0] idx_inc;

	assign tick = cnt_reg == 4'(`TS_CYCLES - 1);
	assign act = tick && ts_reg == 2'h3;
	assign xfer_ok = parity_ok(lat_reg);
	assign fn = lat_reg.data[`FN_MSB:`FN_LSB]; // RULE_18
	// Only primary memory space is ours; no I/O registers answer here
	assign mem_cmd = xfer_ok && lat_reg.tag == `TAG_CMD && !lat_reg.data[`IO_SPACE_BIT]; // RULE_11
	assign idx_inc = idx_reg + `MEM_IDX_W'(1);

	// Stored parity stands in for check bits, so corrections never occur here
	function automatic logic [3:0] integrity(logic [`MEM_IDX_W-1:0] i);
		return (^mem_reg[i] != mem_par_reg[i]) ? `INTEG_UNCORRECTABLE : `INTEG_OK;
	endfunction

	////////////////////////////////////////////////////////////////////////////////////////
	// Next-state logic: time states, receive latch, command decode and arbitration
	always_comb begin
		cnt_next = tick ? 4'h0 : cnt_reg + 4'h1;
		ts_next = tick ? ts_reg + 2'h1 : ts_reg; // RULE_24
		state_next = state_reg;
		lat_next = lat_reg;
		ltr_next = ltr_reg;
		trv_next = trv_reg;
		out_next = out_reg;
		oe_next = oe_reg;
		cnf_pend_next = cnf_pend_reg;
		cnf_out_next = cnf_out_reg;
		id_next = id_reg;
		idx_next = idx_reg;
		ext_next = ext_reg;
		perr_next = 1'b0;
		mem_we = 1'b0;
		mem_widx = idx_reg;
		mem_wword = 32'h0;
		// Receivers look only at what was latched, never the live lines
		if (tick && ts_reg == 2'h2) begin
			lat_next = bus.info; // RULE_21
			ltr_next = bus.req_lines;
		end
		if (act) begin
			// Answer for the transfer latched one bus cycle back
			cnf_out_next = cnf_pend_reg; // RULE_22
			cnf_pend_next = `CNF_NONE;
			perr_next = !xfer_ok; // RULE_08
			case (state_reg)
				M_IDLE: begin
					if (mem_cmd) begin // RULE_09
						idx_next = lat_reg.data[`MEM_IDX_W-1:0];
						ext_next = is_ext(fn);
						if (is_read(fn)) begin // RULE_23
							id_next = lat_reg.id; // RULE_10
							trv_next[MEM_LINE] = 1'b1; // RULE_03
							cnf_pend_next = `CNF_ACK;
							state_next = M_ARB;
						end else if (is_write(fn)) begin // RULE_23
							cnf_pend_next = `CNF_ACK;
							state_next = M_WDATA;
						end else begin
							cnf_pend_next = `CNF_ERR;
						end
					end
				end
				M_WDATA: begin
					// Data must sit in the very next cycle or the write is dropped
					if (xfer_ok && lat_reg.tag == `TAG_WDATA) begin // RULE_14
						mem_we = 1'b1;
						mem_wword = merge_bytes(mem_reg[idx_reg], lat_reg.data, lat_reg.mask); // RULE_20
						cnf_pend_next = `CNF_ACK;
						if (ext_reg) begin
							ext_next = 1'b0;
							idx_next = idx_inc;
						end else begin
							state_next = M_IDLE;
						end
					end else begin
						state_next = M_IDLE;
					end
				end
				M_ARB: begin
					if (mem_cmd) begin
						cnf_pend_next = `CNF_BUSY;
					end
					// Lines above ours, hold line included, block the win
					if ((ltr_reg & higher_lines(MEM_LINE)) == 16'h0) begin // RULE_04
						trv_next[MEM_LINE] = 1'b0;
						trv_next[`HOLD_LINE] = ext_reg; // RULE_02
						oe_next = 1'b1;
						// RULE_12 RULE_13 RULE_19
						out_next = make_info(`TAG_RDATA, id_reg, integrity(idx_reg), mem_reg[idx_reg]);
						state_next = M_SEND;
					end else begin
						trv_next[MEM_LINE] = 1'b1; // RULE_06
					end
				end
				M_SEND: begin
					if (mem_cmd) begin
						cnf_pend_next = `CNF_BUSY;
					end
					if (ext_reg) begin
						// Second longword rides on the cycle the hold line reserved
						out_next = make_info(`TAG_RDATA, id_reg, integrity(idx_inc), mem_reg[idx_inc]);
						trv_next[`HOLD_LINE] = 1'b0;
						ext_next = 1'b0;
						idx_next = idx_inc;
					end else begin
						oe_next = 1'b0;
						out_next = '0;
						state_next = M_IDLE;
					end
				end
				default: begin
					state_next = M_IDLE;
				end
			endcase
		end
		busy_next = state_next != M_IDLE;
	end

	// Control registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= M_IDLE;
			cnt_reg <= 4'h0;
			ts_reg <= 2'h0;
			lat_reg <= '0;
			ltr_reg <= 16'h0;
			trv_reg <= 16'h0;
			out_reg <= '0;
			oe_reg <= 1'b0;
			cnf_pend_reg <= `CNF_NONE;
			cnf_out_reg <= `CNF_NONE;
			id_reg <= 5'h00;
			idx_reg <= `MEM_IDX_W'(0);
			ext_reg <= 1'b0;
			busy_reg <= 1'b0;
			perr_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			ts_reg <= ts_next;
			lat_reg <= lat_next;
			ltr_reg <= ltr_next;
			trv_reg <= trv_next;
			out_reg <= out_next;
			oe_reg <= oe_next;
			cnf_pend_reg <= cnf_pend_next;
			cnf_out_reg <= cnf_out_next;
			id_reg <= id_next;
			idx_reg <= idx_next;
			ext_reg <= ext_next;
			busy_reg <= busy_next;
			perr_reg <= perr_next;
		end
	end

	// Storage array; contents are not reset, like real memory
	always_ff @(posedge clk_i) begin
		if (mem_we) begin
			mem_reg[mem_widx] <= mem_wword;
			mem_par_reg[mem_widx] <= ^mem_wword;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// Bus and user outputs, all from registers
	assign bus.mem_req_lines = trv_reg; // RULE_01
	assign bus.mem_info = out_reg; // RULE_07
	assign bus.mem_info_oe = oe_reg;
	assign bus.mem_cnf = cnf_out_reg;
	assign busy_o = busy_reg;
	assign parity_err_o = perr_reg;

endmodule

/* bus_link_properties.sv */
`timescale 1ns/100ps
`include "bus_node_cfg.svh"

module bus_link_properties import bus_types_pkg::*; #(
	parameter int NODE_LINE = 5,
	parameter int MEM_LINE = 2
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [15:0] req_lines,
	input wire logic [15:0] node_req_lines,
	input wire logic [15:0] mem_req_lines,
	input wire info_t info,
	input wire logic mem_info_oe,
	input wire logic node_info_oe,
	input wire logic [1:0] mem_cnf,
	input wire logic [1:0] cnf
);
	localparam logic [15:0] NODE_HI = 16'((32'h1 << NODE_LINE) - 32'h1);
	localparam logic [15:0] MEM_HI = 16'((32'h1 << MEM_LINE) - 32'h1);

	////////////////////////////////////////
	logic [5:0] phase_reg;
	logic [5:0] phase_next;

	// Own bus-cycle phase; both ends start theirs on the same reset release
	always_comb begin
		phase_next = (phase_reg == 6'h2F) ? 6'h00 : phase_reg + 6'h01;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase_reg <= 6'h00;
		end else begin
			phase_reg <= phase_next;
		end
	end

	// Decode of the word on the lines, used only as antecedents and in the cov_write cover
	wire [3:0] fn = info.data[`FN_MSB:`FN_LSB];
	wire cmd_on = node_info_oe && info.tag == `TAG_CMD;
	wire wr_fn = fn == `FN_WRITE || fn == `FN_ILK_WRITE || fn == `FN_EXT_WRITE;
	wire known_fn = wr_fn || fn == `FN_READ || fn == `FN_ILK_READ || fn == `FN_EXT_READ;
	wire mem_space = !info.data[`IO_SPACE_BIT];
	wire mid = phase_reg == 6'h18; // Middle of a cycle, so each word triggers once

	////////////////////////////////////////
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	chk_even_parity: assert property (
		(node_info_oe || mem_info_oe) |-> (^{info.tag, info.id, info.mask, info.par[0]} == 1'b0)
		&& (^{info.data, info.par[1]} == 1'b0))
		else $error("odd parity on a driven word");
	// Lines only move on the cycle boundary, so the latch window sees settled values
	chk_lines_cycle: assert property (
		($changed(info) || $changed(req_lines)) |-> phase_reg == 6'h00)
		else $error("bus lines changed inside a cycle");
	chk_cnf_cycle: assert property (
		$changed(cnf) |-> phase_reg == 6'h00)
		else $error("confirmation changed inside a cycle");
	chk_node_win: assert property (
		$rose(node_info_oe) |-> $past(node_req_lines[NODE_LINE], 24)
		&& !node_req_lines[NODE_LINE] && (($past(req_lines, 24) & NODE_HI) == 16'h0000))
		else $error("commander took the lines without a clear win");
	chk_mem_win: assert property (
		$rose(mem_info_oe) |-> $past(mem_req_lines[MEM_LINE], 24)
		&& !mem_req_lines[MEM_LINE] && (($past(req_lines, 24) & MEM_HI) == 16'h0000))
		else $error("memory took the lines without a clear win");
	chk_node_keeps_req: assert property (
		$fell(node_req_lines[NODE_LINE]) |-> $rose(node_info_oe))
		else $error("commander dropped its request without winning");
	chk_mem_keeps_req: assert property (
		$fell(mem_req_lines[MEM_LINE]) |-> $rose(mem_info_oe))
		else $error("memory dropped its request without winning");
	chk_write_hold: assert property (
		cmd_on && wr_fn |-> node_req_lines[`HOLD_LINE])
		else $error("write command without the hold line");
	chk_wdata_next: assert property (
		mid && cmd_on && wr_fn |-> ##48 node_info_oe && info.tag == `TAG_WDATA
		&& info.id == 5'(NODE_LINE))
		else $error("write data not in the next cycle");
	chk_cmd_source: assert property (
		cmd_on |-> info.id == 5'(NODE_LINE) && !mem_info_oe)
		else $error("command word with a wrong source code");
	chk_rdata_format: assert property (
		mem_info_oe |-> info.tag == `TAG_RDATA && info.id == 5'(NODE_LINE)
		&& info.mask == `INTEG_OK)
		else $error("read data with wrong tag, code or integrity");
	chk_ack_delay: assert property (
		mid && ((cmd_on && known_fn && mem_space) || (node_info_oe && info.tag == `TAG_WDATA))
		|-> ##96 mem_cnf == `CNF_ACK)
		else $error("no acknowledge two cycles after the transfer");
	chk_io_silent: assert property (
		mid && cmd_on && !mem_space |-> ##96 mem_cnf == `CNF_NONE)
		else $error("memory answered an I/O space command");
	chk_bad_fn: assert property (
		mid && cmd_on && mem_space && !known_fn |-> ##96 mem_cnf == `CNF_ERR)
		else $error("unknown function not refused");

	cov_write: cover property (mid && cmd_on && wr_fn);
	cov_rdata: cover property ($rose(mem_info_oe));
	cov_err: cover property (mem_cnf == `CNF_ERR);
endmodule

/* tb_top.sv */
`timescale 1ns/100ps
`include "bus_node_cfg.svh"

module tb_top import bus_types_pkg::*; ();

	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic req_valid_i = 1'b0;
	logic [3:0] req_func_i = 4'h0;
	logic [27:0] req_addr_i = 28'h0000000;
	logic [7:0] req_mask_i = 8'h00;
	logic [63:0] req_wdata_i = 64'h0;
	logic req_ready_o, rsp_valid_o, rsp_err_o, busy_o, parity_err_o;
	logic [31:0] rsp_data_o;
	logic [3:0] rsp_integrity_o;
	logic [31:0] got_data;
	logic [3:0] got_integ;
	logic got_err;
	logic perr_seen = 1'b0;
	logic [3:0] bad_fn [3] = '{4'h0, 4'h3, 4'hF};
	int failures = 0;
	int tests_run = 0;

	// 250 MHz
	always #2 clk_i = ~clk_i;

	////////////////////////////////////////
	node_bus_if node_bus_if_inst ();
	mem_node_end #(.MEM_LINE(2)) mem_node_end_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.bus(node_bus_if_inst), .busy_o(busy_o), .parity_err_o(parity_err_o));
	cmd_node_end #(.NODE_LINE(5)) cmd_node_end_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.bus(node_bus_if_inst), .req_valid_i(req_valid_i), .req_func_i(req_func_i),
		.req_addr_i(req_addr_i), .req_mask_i(req_mask_i), .req_wdata_i(req_wdata_i),
		.req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
		.rsp_integrity_o(rsp_integrity_o), .rsp_err_o(rsp_err_o));
	bus_link_properties #(.NODE_LINE(5), .MEM_LINE(2)) bus_link_properties_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .req_lines(node_bus_if_inst.req_lines),
		.node_req_lines(node_bus_if_inst.node_req_lines),
		.mem_req_lines(node_bus_if_inst.mem_req_lines),
		.info(node_bus_if_inst.info), .mem_info_oe(node_bus_if_inst.mem_info_oe),
		.node_info_oe(node_bus_if_inst.node_info_oe), .mem_cnf(node_bus_if_inst.mem_cnf),
		.cnf(node_bus_if_inst.cnf));

	// The error flag is a one-clock pulse, so keep a sticky copy for the end
	always @(posedge clk_i) begin
		if (parity_err_o === 1'b1) begin
			perr_seen <= 1'b1;
		end
	end

	////////////////////////////////////////
	task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic end_sim();
		if (failures == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Request held until taken, then wait for the answer pulse; one op is about 5 bus cycles
	task automatic do_op(input logic [3:0] fn, input logic [27:0] addr, input logic [7:0] mask,
		input logic [63:0] wd);
		int n;
		n = 0;
		req_func_i <= fn;
		req_addr_i <= addr;
		req_mask_i <= mask;
		req_wdata_i <= wd;
		req_valid_i <= 1'b1;
		@(posedge clk_i);
		while (req_ready_o !== 1'b1 && n < 2000) begin
			@(posedge clk_i);
			n++;
		end
		req_valid_i <= 1'b0;
		while (rsp_valid_o !== 1'b1 && n < 2000) begin
			@(posedge clk_i);
			n++;
		end
		check("answer_in_time", n < 2000, 1'h1);
		got_data = rsp_data_o;
		got_integ = rsp_integrity_o;
		got_err = rsp_err_o;
	endtask

	////////////////////////////////////////
	// Plan takes about 4000 clocks; the limit leaves room for slow arbitration
	initial begin
		repeat (30000) @(posedge clk_i);
		failures++;
		end_sim();
	end

	initial begin
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		// Full write, then a partial write over it, then a read with a one-byte mask that returns the full longword
		do_op(`FN_WRITE, 28'h0000003, 8'h0F, 64'h0000_0000_1122_3344);
		check("write_err", got_err, 1'h0);
		do_op(`FN_WRITE, 28'h0000003, 8'h05, 64'h0000_0000_AABB_CCDD);
		do_op(`FN_READ, 28'h0000003, 8'h01, 64'h0);
		check("read_data", got_data, 32'h11BB_33DD);
		check("read_integ", got_integ, `INTEG_OK);
		check("read_err", got_err, 1'h0);
		// Interlock pair behaves as a plain pair
		do_op(`FN_ILK_WRITE, 28'h0000007, 8'h0F, 64'h0000_0000_CAFE_F00D);
		do_op(`FN_ILK_READ, 28'h0000007, 8'h0F, 64'h0);
		check("ilk_data", got_data, 32'hCAFE_F00D);
		// Quadword write, then a partial one touching only the second word
		do_op(`FN_EXT_WRITE, 28'h0000008, 8'hFF, 64'h8765_4321_0FED_CBA9);
		do_op(`FN_EXT_WRITE, 28'h0000008, 8'h90, 64'h5566_7788_1111_1111);
		check("ext_wr_err", got_err, 1'h0);
		do_op(`FN_READ, 28'h0000008, 8'h0F, 64'h0);
		check("ext_word0", got_data, 32'h0FED_CBA9);
		do_op(`FN_READ, 28'h0000009, 8'h0F, 64'h0);
		check("ext_word1", got_data, 32'h5565_4388);
		// Codes outside the six are refused
		foreach (bad_fn[i]) begin
			do_op(bad_fn[i], 28'h0000003, 8'h0F, 64'h0);
			check("bad_fn_err", got_err, 1'h1);
		end
		// I/O space gets no answer from memory
		do_op(`FN_READ, 28'h8000003, 8'h0F, 64'h0);
		check("io_err", got_err, 1'h1);
		do_op(`FN_READ, 28'h0000003, 8'h0F, 64'h0);
		check("after_refused", got_data, 32'h11BB_33DD);
		do_op(`FN_EXT_READ, 28'h0000008, 8'h0F, 64'h0);
		check("ext_read_err", got_err, 1'h0);
		check("ext_rd_word0", got_data, 32'h0FED_CBA9);
		// Second longword comes one bus cycle later; the watchdog guards a hang here
		@(posedge clk_i);
		while (rsp_valid_o !== 1'b1) begin
			@(posedge clk_i);
		end
		check("ext_rd_word1", rsp_data_o, 32'h5565_4388);
		repeat (300) @(posedge clk_i);
		check("parity_flag", perr_seen, 1'h0);
		check("busy_idle", busy_o, 1'h0);
		end_sim();
	end
endmodule
